// *** design/spm_pkg.sv ***
// constants for the spread-spectrum modem parameter block
package spm_pkg;
    localparam logic [6:0] ADDR_FIFO      = 7'h00;
    localparam logic [6:0] ADDR_OPMODE    = 7'h01;
    localparam logic [6:0] ADDR_FIFO_PTR  = 7'h0d;
    localparam logic [6:0] ADDR_STATUS    = 7'h18;
    localparam logic [6:0] ADDR_TXCFG1    = 7'h1d;
    localparam logic [6:0] ADDR_MODCFG    = 7'h1e;
    localparam logic [6:0] ADDR_SYMTO_HI  = 7'h1f;
    localparam logic [6:0] ADDR_SF6_DET   = 7'h31;
    localparam logic [6:0] ADDR_SF6_THR   = 7'h37;

    localparam int OPM_MODEM_BIT  = 7;
    localparam int TXC_BW_LSB     = 4;
    localparam int TXC_CR_LSB     = 1;
    localparam int MOD_SF_LSB     = 4;
    localparam int MOD_CRC_BIT    = 2;
    localparam int SYM_HDRLESS_BIT = 0;

    localparam logic [2:0] MODE_SLEEP   = 3'h0;
    localparam logic [3:0] SF_MIN       = 4'h6;
    localparam logic [3:0] SF_MAX       = 4'hc;
    localparam logic [2:0] CR_MIN       = 3'h1;
    localparam logic [2:0] CR_MAX       = 3'h4;
    localparam logic [3:0] BW_MAX       = 4'h9;
    localparam logic [3:0] BW_250K      = 4'h8;
    localparam logic [2:0] SF6_DET_VAL  = 3'h5;
    localparam logic [7:0] SF6_THR_VAL  = 8'h0c;

    localparam logic [7:0] RST_OPMODE   = 8'h00;
    localparam logic [7:0] RST_TXCFG1   = 8'h72;
    localparam logic [7:0] RST_MODCFG   = 8'h70;
    localparam logic [7:0] RST_SYMTO_HI = 8'h00;
    localparam logic [7:0] RST_SF6_DET  = 8'hc3;
    localparam logic [7:0] RST_SF6_THR  = 8'h0a;

    // total channel width per bandwidth code, in units of 100 Hz
    localparam logic [15:0] BW_TABLE [10] = '{
        16'h004e, 16'h0068, 16'h009c, 16'h00d0, 16'h0138,
        16'h01a1, 16'h0271, 16'h04e2, 16'h09c4, 16'h1388};
endpackage

// *** design/spm_spi_slave.sv ***
// byte-level spi slave, mode 0, sampled on the system clock
`timescale 1ns/1ns
module spm_spi_slave (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       sck,
    input  wire logic       nss_n,
    input  wire logic       mosi,
    input  wire logic [7:0] tx_byte,
    output logic      [7:0] rx_byte,
    output logic            rx_addr,
    output logic            rx_data,
    output logic            miso,
    output logic            miso_oe
);
    typedef struct packed {
        logic       sck_q;
        logic [2:0] cnt;
        logic [7:0] sh_in;
        logic [7:0] sh_out;
        logic       first;
        logic [7:0] rx_byte;
        logic       rx_addr;
        logic       rx_data;
        logic       miso;
        logic       oe;
    } spm_spi_t;

    spm_spi_t s_r, s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rx_addr = 1'b0;
        s_nxt.rx_data = 1'b0;
        s_nxt.sck_q = sck;
        s_nxt.oe = ~nss_n;
        if (nss_n)
        begin
            s_nxt.cnt = 3'h0;
            s_nxt.first = 1'b1;
        end
        else if (sck && !s_r.sck_q)
        begin
            s_nxt.sh_in = {s_r.sh_in[6:0], mosi};
            s_nxt.cnt = s_r.cnt + 3'h1;
            if (s_r.cnt == 3'h7)
            begin
                s_nxt.rx_byte = {s_r.sh_in[6:0], mosi};
                s_nxt.rx_addr = s_r.first;
                s_nxt.rx_data = ~s_r.first;
                s_nxt.first = 1'b0;
            end
        end
        else if (!sck && s_r.sck_q)
        begin
            // the next byte is fetched on the falling edge after a byte ends
            if (s_r.cnt == 3'h0)
            begin
                s_nxt.miso = tx_byte[7];
                s_nxt.sh_out = {tx_byte[6:0], 1'b0};
            end
            else
            begin
                s_nxt.miso = s_r.sh_out[7];
                s_nxt.sh_out = {s_r.sh_out[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            s_r <= '{first: 1'b1, default: '0};
        else
            s_r <= s_nxt;
    end

    assign rx_byte = s_r.rx_byte;
    assign rx_addr = s_r.rx_addr;
    assign rx_data = s_r.rx_data;
    assign miso    = s_r.miso;
    assign miso_oe = s_r.oe;
endmodule // spm_spi_slave

// *** design/spm_modem_params.sv ***
// spread-spectrum modem configuration registers, map swap and data fifo
// Operation
// - modem choice in operating mode register changes only in sleep, then used
// - spread modem selected shows its own register map instead of fsk map
// - spread modem owns a dual-port fifo reached through the spi port
// - spreading code 6 to 12 gives two to that power chips per symbol
// - both ends must use the same spreading code beforehand
// - spreading code 6 forces headerless packets
// - rate codes 1 to 4 select 5/4 to 8/4 coding overhead
// - coding rate can travel in the packet header
// - programmed bandwidth is the total double-sideband channel width
// - 250 and 500 khz bandwidths refused in the 169 mhz band
// - header mode bit sits in the symbol timeout high register
// - headerless links need matching length, rate and checksum setup
`timescale 1ns/1ns
module spm_modem_params (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        sck,
    input  wire logic        nss_n,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe,
    input  wire logic        low_band,
    output logic             modem_sel,
    output logic      [2:0]  op_mode,
    output logic      [12:0] chips_per_symbol,
    output logic      [3:0]  overhead_quarters,
    output logic      [15:0] bandwidth_100hz,
    output logic             headerless,
    output logic             header_carries_cr,
    output logic             crc_on,
    output logic             sf6_ready,
    input  wire logic [7:0]  modem_fifo_addr,
    input  wire logic        modem_fifo_we,
    input  wire logic [7:0]  modem_fifo_wdata,
    output logic      [7:0]  modem_fifo_rdata
);
    typedef struct packed {
        logic [7:0] opmode;
        logic [7:0] fifo_ptr;
        logic [7:0] txcfg;
        logic [7:0] modcfg;
        logic [7:0] symto;
        logic [7:0] sf6det;
        logic [7:0] sf6thr;
        logic [6:0] addr;
        logic       wr;
        logic [7:0] mrd;
    } spm_regs_t;

    spm_regs_t r_r, r_nxt;
    logic [7:0] fifo_mem [256];
    logic [7:0] fsk_bank [128];
    logic [7:0] rx_byte;
    logic       rx_addr;
    logic       rx_data;
    logic [7:0] tx_byte;
    logic       spread;
    logic       spread_reg;
    logic [3:0] sf_code;
    logic [2:0] cr_code;
    logic [3:0] bw_code;
    logic       host_fifo_we;

    spm_spi_slave u_spi (
        .mclk    (mclk),
        .nrst    (nrst),
        .sck     (sck),
        .nss_n   (nss_n),
        .mosi    (mosi),
        .tx_byte (tx_byte),
        .rx_byte (rx_byte),
        .rx_addr (rx_addr),
        .rx_data (rx_data),
        .miso    (miso),
        .miso_oe (miso_oe)
    );

    assign spread  = r_r.opmode[spm_pkg::OPM_MODEM_BIT];
    assign sf_code = r_r.modcfg[spm_pkg::MOD_SF_LSB +: 4];
    assign cr_code = r_r.txcfg[spm_pkg::TXC_CR_LSB +: 3];
    assign bw_code = r_r.txcfg[spm_pkg::TXC_BW_LSB +: 4];

    // addresses that belong to the spread modem's map
    assign spread_reg = spread &&
        (r_r.addr == spm_pkg::ADDR_FIFO ||
         r_r.addr == spm_pkg::ADDR_FIFO_PTR ||
         r_r.addr == spm_pkg::ADDR_STATUS ||
         r_r.addr == spm_pkg::ADDR_TXCFG1 ||
         r_r.addr == spm_pkg::ADDR_MODCFG ||
         r_r.addr == spm_pkg::ADDR_SYMTO_HI ||
         r_r.addr == spm_pkg::ADDR_SF6_DET ||
         r_r.addr == spm_pkg::ADDR_SF6_THR);

    assign host_fifo_we = rx_data && r_r.wr && spread &&
                          r_r.addr == spm_pkg::ADDR_FIFO;

    always_comb
    begin
        tx_byte = fsk_bank[r_r.addr];
        if (r_r.addr == spm_pkg::ADDR_OPMODE)
            tx_byte = r_r.opmode;
        else if (spread_reg)
        begin
            case (r_r.addr)
                spm_pkg::ADDR_FIFO:     tx_byte = fifo_mem[r_r.fifo_ptr];
                spm_pkg::ADDR_FIFO_PTR: tx_byte = r_r.fifo_ptr;
                spm_pkg::ADDR_STATUS:   tx_byte = {5'h00, headerless,
                                                   sf6_ready, spread};
                spm_pkg::ADDR_TXCFG1:   tx_byte = r_r.txcfg;
                spm_pkg::ADDR_MODCFG:   tx_byte = r_r.modcfg;
                spm_pkg::ADDR_SYMTO_HI: tx_byte = r_r.symto;
                spm_pkg::ADDR_SF6_DET:  tx_byte = r_r.sf6det;
                spm_pkg::ADDR_SF6_THR:  tx_byte = r_r.sf6thr;
                default:                tx_byte = 8'h00;
            endcase
        end
    end

    always_comb
    begin
        r_nxt = r_r;
        r_nxt.mrd = fifo_mem[modem_fifo_addr];
        if (rx_addr)
        begin
            r_nxt.addr = rx_byte[6:0];
            r_nxt.wr = rx_byte[7];
        end
        else if (rx_data)
        begin
            // fifo window holds its address so bursts stream the buffer
            if (!(spread_reg && r_r.addr == spm_pkg::ADDR_FIFO))
                r_nxt.addr = r_r.addr + 7'h01;
            else
                r_nxt.fifo_ptr = r_r.fifo_ptr + 8'h01;
            if (r_r.wr && r_r.addr == spm_pkg::ADDR_OPMODE)
            begin
                r_nxt.opmode = rx_byte;
                if (r_r.opmode[2:0] != spm_pkg::MODE_SLEEP)
                    r_nxt.opmode[spm_pkg::OPM_MODEM_BIT] = spread;
            end
            else if (r_r.wr && spread_reg)
            begin
                case (r_r.addr)
                    spm_pkg::ADDR_FIFO_PTR: r_nxt.fifo_ptr = rx_byte;
                    spm_pkg::ADDR_TXCFG1:
                    begin
                        r_nxt.txcfg = rx_byte;
                        if (rx_byte[3:1] < spm_pkg::CR_MIN ||
                            rx_byte[3:1] > spm_pkg::CR_MAX)
                            r_nxt.txcfg[3:1] = cr_code;
                        if (rx_byte[7:4] > spm_pkg::BW_MAX ||
                            (low_band && rx_byte[7:4] >= spm_pkg::BW_250K))
                            r_nxt.txcfg[7:4] = bw_code;
                    end
                    spm_pkg::ADDR_MODCFG:
                    begin
                        r_nxt.modcfg = rx_byte;
                        if (rx_byte[7:4] < spm_pkg::SF_MIN ||
                            rx_byte[7:4] > spm_pkg::SF_MAX)
                            r_nxt.modcfg[7:4] = sf_code;
                    end
                    spm_pkg::ADDR_SYMTO_HI: r_nxt.symto = rx_byte;
                    spm_pkg::ADDR_SF6_DET:  r_nxt.sf6det = rx_byte;
                    spm_pkg::ADDR_SF6_THR:  r_nxt.sf6thr = rx_byte;
                    default:                r_nxt.addr = r_nxt.addr;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            r_r <= '{opmode: spm_pkg::RST_OPMODE,
                     txcfg:  spm_pkg::RST_TXCFG1,
                     modcfg: spm_pkg::RST_MODCFG,
                     symto:  spm_pkg::RST_SYMTO_HI,
                     sf6det: spm_pkg::RST_SF6_DET,
                     sf6thr: spm_pkg::RST_SF6_THR,
                     default: '0};
        end
        else
            r_r <= r_nxt;
    end

    // storage carries no reset; the modem port wins a same-address clash
    always_ff @(posedge mclk)
    begin
        if (rx_data && r_r.wr && !spread_reg &&
            r_r.addr != spm_pkg::ADDR_OPMODE)
            fsk_bank[r_r.addr] <= rx_byte;
        if (host_fifo_we)
            fifo_mem[r_r.fifo_ptr] <= rx_byte;
        if (modem_fifo_we)
            fifo_mem[modem_fifo_addr] <= modem_fifo_wdata;
    end

    assign modem_sel = spread;
    assign op_mode = r_r.opmode[2:0];
    assign modem_fifo_rdata = r_r.mrd;
    assign chips_per_symbol = 13'h0001 << sf_code;
    assign overhead_quarters = {1'b0, cr_code} + 4'h4;
    assign bandwidth_100hz = spm_pkg::BW_TABLE[bw_code];
    // code 6 leaves no room for a header, whatever the mode bit says
    assign headerless = r_r.symto[spm_pkg::SYM_HDRLESS_BIT] ||
                        sf_code == spm_pkg::SF_MIN;
    assign header_carries_cr = ~headerless;
    assign crc_on = r_r.modcfg[spm_pkg::MOD_CRC_BIT];
    // reports whether the host finished the code 6 tuning writes
    assign sf6_ready = sf_code == spm_pkg::SF_MIN &&
                       r_r.sf6det[2:0] == spm_pkg::SF6_DET_VAL &&
                       r_r.sf6thr == spm_pkg::SF6_THR_VAL;

    property p_modem_locked;
        @(posedge mclk) disable iff (!nrst)
        op_mode != spm_pkg::MODE_SLEEP |=> $stable(modem_sel);
    endproperty
    a_modem_locked: assert property (p_modem_locked)
        else $error("modem changed outside sleep");

    property p_modem_follows;
        @(posedge mclk) disable iff (!nrst)
        rx_data && r_r.wr && r_r.addr == spm_pkg::ADDR_OPMODE &&
        op_mode == spm_pkg::MODE_SLEEP |=> modem_sel == $past(rx_byte[7]);
    endproperty
    a_modem_follows: assert property (p_modem_follows)
        else $error("modem select not taken in sleep");

    property p_sf_range;
        @(posedge mclk) disable iff (!nrst)
        sf_code >= spm_pkg::SF_MIN && sf_code <= spm_pkg::SF_MAX &&
        chips_per_symbol == (13'h0001 << sf_code);
    endproperty
    a_sf_range: assert property (p_sf_range)
        else $error("spreading code out of range");

    property p_cr_range;
        @(posedge mclk) disable iff (!nrst)
        overhead_quarters >= 4'h5 && overhead_quarters <= 4'h8;
    endproperty
    a_cr_range: assert property (p_cr_range)
        else $error("coding overhead out of range");

    property p_sf6_headerless;
        @(posedge mclk) disable iff (!nrst)
        sf_code == spm_pkg::SF_MIN |-> headerless && !header_carries_cr;
    endproperty
    a_sf6_headerless: assert property (p_sf6_headerless)
        else $error("code 6 with header");

    property p_lowband_bw;
        @(posedge mclk) disable iff (!nrst)
        low_band && host_fifo_we == 1'b0 && rx_data && r_r.wr && spread &&
        r_r.addr == spm_pkg::ADDR_TXCFG1 && rx_byte[7:4] >= spm_pkg::BW_250K
        |=> $stable(bw_code);
    endproperty
    a_lowband_bw: assert property (p_lowband_bw)
        else $error("wide bandwidth taken in low band");

    property p_fifo_ptr;
        @(posedge mclk) disable iff (!nrst)
        host_fifo_we |=> r_r.fifo_ptr == $past(r_r.fifo_ptr) + 8'h01
                         ##1 fifo_mem[$past(r_r.fifo_ptr, 2)]
                             == $past(rx_byte, 2);
    endproperty
    a_fifo_ptr: assert property (p_fifo_ptr)
        else $error("fifo write lost");

    // fsk-mode writes land in the fsk bank, spread register untouched
    property p_map_swap;
        @(posedge mclk) disable iff (!nrst)
        rx_data && r_r.wr && !spread && r_r.addr == spm_pkg::ADDR_TXCFG1
        |=> fsk_bank[spm_pkg::ADDR_TXCFG1] == $past(rx_byte) &&
            $stable(r_r.txcfg);
    endproperty
    a_map_swap: assert property (p_map_swap)
        else $error("fsk map not shown");
endmodule // spm_modem_params

// *** bench/spm_host.sv ***
// host-side spi master model driving the register port
`timescale 1ns/1ns
module spm_host (
    input  wire logic       mclk,
    output logic            sck,
    output logic            nss_n,
    output logic            mosi,
    input  wire logic       miso,
    input  wire logic       miso_oe,
    output logic      [7:0] rd_data,
    output logic            rd_v
);
    logic last;
    initial
    begin
        sck = 1'b0;
        nss_n = 1'b1;
        mosi = 1'b0;
        rd_data = 8'h00;
        rd_v = 1'b0;
        last = 1'b0;
    end
    // one address byte, one data byte; sck phases of 4 mclk
    task automatic xfer(input logic wr, input logic [6:0] a,
                        input logic [7:0] d);
        logic [15:0] sh;
        logic [7:0]  rx;
        sh = {wr, a, d};
        rx = 8'h00;
        nss_n = 1'b0;
        repeat (4) @(negedge mclk);
        for (int i = 15; i >= 0; i--)
        begin
            mosi = sh[i];
            repeat (4) @(negedge mclk);
            // undriven miso shows the inverse, not a stale bit
            if (i < 8)
            begin
                last = miso_oe ? miso : ~last;
                rx[i] = last;
            end
            sck = 1'b1;
            repeat (4) @(negedge mclk);
            sck = 1'b0;
        end
        repeat (4) @(negedge mclk);
        nss_n = 1'b1;
        mosi = ~mosi;
        rd_data = rx;
        rd_v = ~wr;
        @(negedge mclk);
        rd_v = 1'b0;
        repeat (2) @(negedge mclk);
    endtask
endmodule // spm_host

// *** bench/tb.sv ***
// self-checking bench for the modem parameter block
`timescale 1ns/1ns
module tb;
    logic        mclk, nrst, sck, nss_n, mosi, miso, miso_oe, low_band;
    logic        modem_sel, headerless, hcc, crc_on, sf6_ready;
    logic        f_we, rd_v, look_v;
    logic [2:0]  op_mode, look_sel;
    logic [12:0] chips;
    logic [3:0]  ovh, bc;
    logic [15:0] bw, lv, got, ex, nx;
    logic [7:0]  f_addr, f_wdata, f_rdata, rd_data, d0, d1;
    logic [31:0] seed;
    logic [15:0] expq [$];
    logic [15:0] bwv [10] = '{16'h004e, 16'h0068, 16'h009c, 16'h00d0,
        16'h0138, 16'h01a1, 16'h0271, 16'h04e2, 16'h09c4, 16'h1388};
    int          err_total, compares;

    spm_modem_params dut (.mclk(mclk), .nrst(nrst), .sck(sck),
        .nss_n(nss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .low_band(low_band), .modem_sel(modem_sel), .op_mode(op_mode),
        .chips_per_symbol(chips), .overhead_quarters(ovh),
        .bandwidth_100hz(bw), .headerless(headerless),
        .header_carries_cr(hcc), .crc_on(crc_on), .sf6_ready(sf6_ready),
        .modem_fifo_addr(f_addr), .modem_fifo_we(f_we),
        .modem_fifo_wdata(f_wdata), .modem_fifo_rdata(f_rdata));
    spm_host host (.mclk(mclk), .sck(sck), .nss_n(nss_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .rd_data(rd_data), .rd_v(rd_v));

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always_comb
    begin
        case (look_sel)
            3'h0: lv = {12'h000, modem_sel, op_mode};
            3'h1: lv = {3'h0, chips};
            3'h2: lv = {12'h000, ovh};
            3'h3: lv = bw;
            3'h4: lv = {12'h000, headerless, hcc, crc_on, sf6_ready};
            default: lv = {8'h00, f_rdata};
        endcase
    end

    // oldest note is matched to whatever result shows up
    always @(posedge mclk)
    begin
        if (rd_v === 1'b1 || look_v === 1'b1)
        begin
            got = (rd_v === 1'b1) ? {8'h00, rd_data} : lv;
            ex = expq.pop_front();
            compares++;
            if (got !== ex)
            begin
                err_total++;
                $display("ERROR %0t: got %h exp %h", $time, got, ex);
            end
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        expq.push_back({8'h00, e});
        host.xfer(1'b0, a, 8'h00);
    endtask

    task automatic look(input logic [2:0] s, input logic [15:0] e);
        expq.push_back(e);
        look_sel = s;
        look_v = 1'b1;
        @(negedge mclk);
        look_v = 1'b0;
        @(negedge mclk);
    endtask

    task automatic stop_test();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (50000) @(posedge mclk);
        err_total++;
        stop_test();
    end

    initial
    begin
        nrst = 1'b0;
        low_band = 1'b0;
        f_addr = 8'h00;
        f_we = 1'b0;
        f_wdata = 8'h00;
        look_sel = 3'h0;
        look_v = 1'b0;
        err_total = 0;
        compares = 0;
        seed = 32'h93bf98b9;
        repeat (3) @(negedge mclk);
        nrst = 1'b1;
        look(3'h0, 16'h0000);
        look(3'h1, 16'h0080);
        look(3'h2, 16'h0005);
        look(3'h3, 16'h04e2);
        look(3'h4, 16'h0004);
        wr(spm_pkg::ADDR_TXCFG1, 8'h94);
        look(3'h3, 16'h04e2);
        rd(spm_pkg::ADDR_TXCFG1, 8'h94);
        wr(spm_pkg::ADDR_OPMODE, 8'h01);
        wr(spm_pkg::ADDR_OPMODE, 8'h81);
        look(3'h0, 16'h0001);
        wr(spm_pkg::ADDR_OPMODE, 8'h80);
        look(3'h0, 16'h0000);
        wr(spm_pkg::ADDR_OPMODE, 8'h80);
        look(3'h0, 16'h0008);
        rd(spm_pkg::ADDR_OPMODE, 8'h80);
        rd(spm_pkg::ADDR_TXCFG1, 8'h72);
        // all ten codes in the normal band, then 8, 9 and 10 in the low band
        for (int c = 0; c < 13; c++)
        begin
            low_band = (c > 9);
            bc = (c > 9) ? 4'(c - 2) : c[3:0];
            wr(spm_pkg::ADDR_TXCFG1, {bc, 4'h2});
            look(3'h3, (c < 10) ? bwv[c] : 16'h1388);
        end
        low_band = 1'b0;
        nx = 16'h0005;
        for (int r = 0; r < 8; r++)
        begin
            wr(spm_pkg::ADDR_TXCFG1, {4'h7, r[2:0], 1'b0});
            if (r >= 1 && r <= 4)
                nx = 16'(4 + r);
            look(3'h2, nx);
        end
        nx = 16'h0080;
        for (int s = 5; s < 14; s++)
        begin
            wr(spm_pkg::ADDR_MODCFG, {s[3:0], 4'h4});
            if (s >= 6 && s <= 12)
                nx = 16'h0001 << s;
            look(3'h1, nx);
        end
        wr(spm_pkg::ADDR_SYMTO_HI, 8'h01);
        look(3'h4, 16'h000a);
        wr(spm_pkg::ADDR_SYMTO_HI, 8'h00);
        look(3'h4, 16'h0006);
        rd(spm_pkg::ADDR_SF6_DET, 8'hc3);
        rd(spm_pkg::ADDR_SF6_THR, 8'h0a);
        wr(spm_pkg::ADDR_MODCFG, 8'h64);
        look(3'h4, 16'h000a);
        wr(spm_pkg::ADDR_SF6_DET, 8'hc5);
        wr(spm_pkg::ADDR_SF6_THR, 8'h0c);
        look(3'h4, 16'h000b);
        rd(spm_pkg::ADDR_STATUS, 8'h07);
        rd(spm_pkg::ADDR_SF6_DET, 8'hc5);
        seed = xs(seed);
        d0 = seed[7:0];
        seed = xs(seed);
        d1 = seed[7:0];
        wr(spm_pkg::ADDR_FIFO_PTR, 8'h10);
        wr(spm_pkg::ADDR_FIFO, d0);
        wr(spm_pkg::ADDR_FIFO, d1);
        f_addr = 8'h10;
        @(negedge mclk);
        look(3'h5, {8'h00, d0});
        f_addr = 8'h11;
        @(negedge mclk);
        look(3'h5, {8'h00, d1});
        seed = xs(seed);
        f_addr = 8'h20;
        f_wdata = seed[7:0];
        f_we = 1'b1;
        @(negedge mclk);
        f_we = 1'b0;
        wr(spm_pkg::ADDR_FIFO_PTR, 8'h20);
        rd(spm_pkg::ADDR_FIFO, seed[7:0]);
        stop_test();
    end
endmodule // tb
